// *** verilog/clock_switch_regs.svh ***
// Timing counts and pin positions of the glitchless clock switch.
`ifndef CLOCK_SWITCH_REGS_SVH
`define CLOCK_SWITCH_REGS_SVH

`define GCS_N_OUT            8
`define GCS_N_PINS           6
`define GCS_PIN_IN0          0
`define GCS_PIN_IN1          1
`define GCS_PIN_OK0          2
`define GCS_PIN_OK1          3
`define GCS_PIN_SEL          4
`define GCS_PIN_RDP          5
`define GCS_PIN_RESET_VAL    6'h10
`define GCS_HIGH_HOLD_FALLS  3'h2
`define GCS_LOW_HOLD_FALLS   3'h2
`define GCS_MAX_SWITCH_FALLS 5'h11
`define GCS_INIT_CYCLES      16'h0040

`endif

// *** verilog/clock_switch_pkg.sv ***
// Types shared by the glitchless clock switch.
`default_nettype none
package clock_switch_pkg;
   typedef enum logic [3:0] {
      ST_INIT    = 4'h1,
      ST_FOLLOW  = 4'h2,
      ST_HOLD_HI = 4'h4,
      ST_HOLD_LO = 4'h8
   } switch_state_e;
endpackage
`default_nettype wire

// *** verilog/pin_level_if.sv ***
// Carrier for filtered pin levels between the filter and the switch.
`timescale 1ns/10ps
`default_nettype none
interface pin_level_if #(parameter int W = 6);
   logic [W-1:0] level;
   modport src (output level);
   modport dst (input level);
endinterface
`default_nettype wire

// *** verilog/pin_filter.sv ***
// Three-stage pin synchroniser with agreement filter, one per pin.
`timescale 1ns/10ps
`default_nettype none
module pin_filter #(
   parameter int           W       = 6,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         mclk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] pins_i,
   pin_level_if.src          lvl
);
   ////////////////////////////////////////////////////////////////////////////
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] lvl_q;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_pin
         // A level only counts once two settled stages agree, so a half-resolved
         // sample never reaches the switch logic.
         always_ff @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               s1_q[i]  <= RST_VAL[i];
               s2_q[i]  <= RST_VAL[i];
               s3_q[i]  <= RST_VAL[i];
               lvl_q[i] <= RST_VAL[i];
            end else begin
               s1_q[i] <= pins_i[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               if (s2_q[i] == s3_q[i]) begin
                  lvl_q[i] <= s3_q[i];
               end
            end
         end
      end
   endgenerate

   assign lvl.level = lvl_q;
endmodule // pin_filter
`default_nettype wire

// *** verilog/glitchless_clock_switch_mux.sv ***
// Runt-free 2:1 clock switch with fail-safe hold and eight output copies.
// Notes on behaviour
// - Old clock stuck high: hold output high first.
// - Then drive low for new falls, then follow.
// - Stretched cycle phases exceed half new period.
// - Old clock stuck low: low hold, then follow.
// - Lost amplitude: use last valid registered level.
// - Dead selected input keeps output at stable level.
// - Slowly degrading toggling input passes unfiltered.
// - Power-up init puts switch logic in known state.
// - Delay pin at supply: plain immediate multiplexer.
// - Unconnected select reads high, choosing input one.
// - Healthy clocks: old, low gap, then new.
// - New clock followed within seventeen input cycles.
`timescale 1ns/10ps
`default_nettype none
`include "clock_switch_regs.svh"
module glitchless_clock_switch_mux
   import clock_switch_pkg::*;
(
   input  wire logic                 mclk_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 clock_input_zero_i,
   input  wire logic                 clock_input_one_i,
   input  wire logic                 amp_ok_zero_i,
   input  wire logic                 amp_ok_one_i,
   input  wire logic                 sel_i,
   input  wire logic                 reset_delay_pin_i,
   output logic [`GCS_N_OUT-1:0]     fanout_outputs_o,
   output logic                      switch_busy_o
);
   ////////////////////////////////////////////////////////////////////////////
   pin_level_if #(.W(`GCS_N_PINS)) pins ();

   // The select pin resets high, as an open pin would read.
   pin_filter #(
      .W       (`GCS_N_PINS),
      .RST_VAL (`GCS_PIN_RESET_VAL)
   ) u_filter (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .pins_i  ({reset_delay_pin_i, sel_i, amp_ok_one_i, amp_ok_zero_i,
                 clock_input_one_i, clock_input_zero_i}),
      .lvl     (pins)
   );

   ////////////////////////////////////////////////////////////////////////////
   switch_state_e          state_q;
   switch_state_e          state_d;
   logic                   cur_sel_q;
   logic                   cur_sel_d;
   logic                   old_sel_q;
   logic                   old_sel_d;
   logic [2:0]             cnt_q;
   logic [2:0]             cnt_d;
   logic [15:0]            init_cnt_q;
   logic                   out_d;
   logic                   last0_q;
   logic                   last1_q;
   logic                   new_prev_q;
   logic [`GCS_N_OUT-1:0]  fan_q;
   logic                   busy_q;

   wire logic [`GCS_N_PINS-1:0] lv = pins.level;
   wire logic eff0       = lv[`GCS_PIN_OK0] ? lv[`GCS_PIN_IN0] : last0_q;
   wire logic eff1       = lv[`GCS_PIN_OK1] ? lv[`GCS_PIN_IN1] : last1_q;
   wire logic eff_cur    = cur_sel_q ? eff1 : eff0;
   wire logic eff_old    = old_sel_q ? eff1 : eff0;
   wire logic sel_lvl    = lv[`GCS_PIN_SEL];
   wire logic bypass     = lv[`GCS_PIN_RDP];
   wire logic sel_chg    = sel_lvl != cur_sel_q;
   wire logic new_fall   = new_prev_q & ~eff_cur;
   wire logic init_done  = init_cnt_q == (`GCS_INIT_CYCLES - 16'h0001);
   wire logic hi_done    = new_fall && (cnt_q == `GCS_HIGH_HOLD_FALLS - 3'h1);
   wire logic lo_done    = new_fall && (cnt_q == `GCS_LOW_HOLD_FALLS - 3'h1);
   wire logic [2:0] cnt_inc = cnt_q + 3'h1;

   // Toggling inputs are not filtered for duty or width: only a lost amplitude
   // freezes the level, so a slowly dying clock may still pass short pulses.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         last0_q <= 1'b0;
         last1_q <= 1'b0;
      end else begin
         if (lv[`GCS_PIN_OK0]) begin
            last0_q <= lv[`GCS_PIN_IN0];
         end
         if (lv[`GCS_PIN_OK1]) begin
            last1_q <= lv[`GCS_PIN_IN1];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d   = state_q;
      cur_sel_d = cur_sel_q;
      old_sel_d = old_sel_q;
      cnt_d     = cnt_q;
      out_d     = 1'b0;
      case (state_q)
         ST_INIT: begin
            cur_sel_d = sel_lvl;
            old_sel_d = sel_lvl;
            if (init_done) begin
               state_d = ST_FOLLOW;
            end
         end
         ST_FOLLOW: begin
            out_d = eff_cur;
            if (sel_chg) begin
               cur_sel_d = sel_lvl;
               old_sel_d = cur_sel_q;
               cnt_d     = 3'h0;
               if (bypass) begin
                  out_d = sel_lvl ? eff1 : eff0;
               end else if (eff_cur) begin
                  state_d = ST_HOLD_HI;
               end else begin
                  state_d = ST_HOLD_LO;
               end
            end
         end
         ST_HOLD_HI: begin
            out_d = eff_old;
            if (bypass) begin
               state_d = ST_FOLLOW;
            end else if (!eff_old || hi_done) begin
               state_d = ST_HOLD_LO;
               cnt_d   = 3'h0;
               out_d   = 1'b0;
            end else if (new_fall) begin
               cnt_d = cnt_inc;
            end
         end
         ST_HOLD_LO: begin
            // Outside bypass, leaving only on a new-clock falling edge keeps the low phase
            // at least half a period of the new clock.
            if (bypass || lo_done) begin
               state_d = ST_FOLLOW;
            end else if (new_fall) begin
               cnt_d = cnt_inc;
            end
         end
         default: begin
            state_d = ST_INIT;
         end
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q    <= ST_INIT;
         cur_sel_q  <= 1'b1;
         old_sel_q  <= 1'b1;
         cnt_q      <= 3'h0;
         new_prev_q <= 1'b0;
         busy_q     <= 1'b1;
      end else begin
         state_q    <= state_d;
         cur_sel_q  <= cur_sel_d;
         old_sel_q  <= old_sel_d;
         cnt_q      <= cnt_d;
         new_prev_q <= cur_sel_d ? eff1 : eff0;
         busy_q     <= state_d != ST_FOLLOW;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         init_cnt_q <= 16'h0000;
      end else if (state_q == ST_INIT) begin
         init_cnt_q <= init_cnt_q + 16'h0001;
      end
   end

   genvar k;
   generate
      for (k = 0; k < `GCS_N_OUT; k++) begin : g_fan
         always_ff @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               fan_q[k] <= 1'b0;
            end else begin
               fan_q[k] <= out_d;
            end
         end
      end
   endgenerate

   assign fanout_outputs_o = fan_q;
   assign switch_busy_o    = busy_q;

   ////////////////////////////////////////////////////////////////////////////
   logic [4:0] hold_falls_q;
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hold_falls_q <= 5'h00;
      end else if (state_q == ST_FOLLOW || state_q == ST_INIT) begin
         // Falls seen during initialisation belong to no switchover.
         hold_falls_q <= 5'h00;
      end else if (new_fall && hold_falls_q != 5'h1F) begin
         hold_falls_q <= hold_falls_q + 5'h01;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   AST_HOLD_HIGH: assert property (
      (state_q == ST_HOLD_HI && eff_old && !bypass && !hi_done) |=> fan_q[0])
      else $error("Output not held high while old clock is high.");
   AST_HOLD_LOW: assert property (
      (state_q == ST_HOLD_LO) |=> !fan_q[0])
      else $error("Output not low during low hold.");
   AST_LOW_PHASE: assert property (
      ($past(state_q) == ST_HOLD_LO && state_q == ST_FOLLOW) |-> !fan_q[0] && !eff_cur)
      else $error("Low hold ended while new clock was high.");
   AST_FAILED_LOW: assert property (
      (state_q == ST_FOLLOW && sel_chg && !bypass && !eff_cur) |=> state_q == ST_HOLD_LO)
      else $error("Low old clock did not start the low hold.");
   AST_LAST_VALID: assert property (
      (state_q == ST_FOLLOW && !sel_chg && !cur_sel_q && !lv[`GCS_PIN_OK0])
      |=> fan_q[0] == $past(last0_q))
      else $error("Dead input did not show its last valid level.");
   AST_FAILSAFE_STABLE: assert property (
      (state_q == ST_FOLLOW && !sel_chg && cur_sel_q && !lv[`GCS_PIN_OK1]) [*2]
      |=> $stable(fan_q[0]))
      else $error("Output moved while selected input was dead.");
   AST_INIT_LOW: assert property (
      (state_q == ST_INIT) |=> !fan_q[0] && busy_q == (state_q != ST_FOLLOW))
      else $error("Output active during initialisation.");
   AST_BYPASS: assert property (
      (state_q == ST_FOLLOW && sel_chg && bypass)
      |=> state_q == ST_FOLLOW && cur_sel_q == $past(sel_lvl))
      else $error("Bypass did not switch at once.");
   AST_SWITCH_BOUND: assert property (
      hold_falls_q < `GCS_MAX_SWITCH_FALLS)
      else $error("Switchover took too many new-clock falls.");
   AST_COPIES: assert property (
      ($past(state_q) == ST_FOLLOW) |-> (fan_q == {`GCS_N_OUT{fan_q[0]}})
      && fan_q[0] == $past(out_d) && ($past(sel_chg) || fan_q[0] == $past(eff_cur)))
      else $error("Outputs do not carry the selected clock.");

   COV_HOLD_HI: cover property (state_q == ST_FOLLOW ##1 state_q == ST_HOLD_HI);
   COV_HOLD_LO: cover property (state_q == ST_HOLD_HI ##1 state_q == ST_HOLD_LO);
   COV_DONE:    cover property (state_q == ST_HOLD_LO ##1 state_q == ST_FOLLOW);
   COV_BYPASS:  cover property (state_q == ST_FOLLOW && sel_chg && bypass);
endmodule // glitchless_clock_switch_mux
`default_nettype wire

// *** verif/clock_pair_model.sv ***
// Behavioural model of the two redundant clock sources in front of the switch.
`timescale 1ns/10ps
`default_nettype none
module clock_pair_model #(
   parameter int HALF0 = 5,
   parameter int HALF1 = 6
) (
   input  wire logic       mclk_i,
   input  wire logic [1:0] run_i,
   input  wire logic [1:0] lvl_i,
   input  wire logic [1:0] noise_i,
   output logic      [1:0] clk_o
);
   int cnt [2];
   initial begin
      clk_o = 2'h0;
      cnt = '{0, 0};
   end
   // Noise toggles every cycle so a dead input never looks like a clean level.
   always @(negedge mclk_i) begin
      for (int i = 0; i < 2; i++) begin
         if (noise_i[i]) begin
            clk_o[i] <= ~clk_o[i];
            cnt[i]   <= cnt[i] + 1;
         end else if (!run_i[i]) begin
            clk_o[i] <= lvl_i[i];
            cnt[i]   <= 0;
         end else if (cnt[i] >= (i ? HALF1 : HALF0) - 1) begin
            clk_o[i] <= ~clk_o[i];
            cnt[i]   <= 0;
         end else begin
            cnt[i] <= cnt[i] + 1;
         end
      end
   end
endmodule // clock_pair_model
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench of the glitchless clock switch.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module testbench;
   localparam int HALF0 = 5;
   localparam int HALF1 = 6;
   typedef struct packed {
      logic       en;
      logic       s;
      logic [1:0] l;
      logic [7:0] e;
   } row_s;
   logic       mclk, rst_n, amp0, amp1, bypass, sel_v, sel_en, busy;
   logic [1:0] run, lvl, noise, clk;
   logic [7:0] fan, first;
   int         hi, errors, compares;
   tri1        sel_w;
   // Released select floats up through the pull-up, as an open pin would.
   assign sel_w = sel_en ? sel_v : 1'bz;
   row_s rows [5] = '{'{1'b1, 1'b0, 2'h2, 8'h00}, '{1'b1, 1'b0, 2'h1, 8'hFF},
                      '{1'b1, 1'b1, 2'h2, 8'hFF}, '{1'b1, 1'b1, 2'h1, 8'h00},
                      '{1'b0, 1'b0, 2'h2, 8'hFF}};
   glitchless_clock_switch_mux dut (.mclk_i(mclk), .rst_n_i(rst_n),
      .clock_input_zero_i(clk[0]), .clock_input_one_i(clk[1]),
      .amp_ok_zero_i(amp0), .amp_ok_one_i(amp1), .sel_i(sel_w),
      .reset_delay_pin_i(bypass), .fanout_outputs_o(fan), .switch_busy_o(busy));
   clock_pair_model #(.HALF0(HALF0), .HALF1(HALF1)) src (.mclk_i(mclk),
      .run_i(run), .lvl_i(lvl), .noise_i(noise), .clk_o(clk));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task report_and_stop;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic wait_busy(input logic v);
      int n;
      n = 0;
      while (busy !== v) begin
         cyc(1);
         n++;
         if (n > 400) begin
            errors++;
            $display("CHECK FAILED busy expected %0h seen %0h", v, busy);
            report_and_stop();
         end
      end
   endtask
   // Watches one suppressed switchover; every sample while busy must be a whole copy set.
   task automatic switch_to(input logic ns, output logic [7:0] f, output int h);
      int n, lo, rises, falls, flips, bad;
      logic [7:0] p;
      logic c;
      {n, lo, rises, falls, flips, bad, h} = '0;
      sel_v = ns;
      wait_busy(1'b1);
      f = fan;
      while (busy === 1'b1 && n < 600) begin
         p = fan;
         c = clk[ns];
         cyc(1);
         n++;
         h += (fan === 8'hFF);
         lo += (fan === 8'h00);
         rises += (p === 8'h00 && fan === 8'hFF);
         falls += (c === 1'b1 && clk[ns] === 1'b0);
         bad += (fan !== 8'h00 && fan !== 8'hFF);
      end
      while (fan !== 8'hFF && n < 600) begin
         cyc(1);
         n++;
         lo++;
      end
      if (n >= 600) begin
         errors++;
         $display("CHECK FAILED switch expected %0d seen %0d", 600, n);
         report_and_stop();
      end
      repeat (48) begin
         p = fan;
         cyc(1);
         flips += (fan !== p);
      end
      `CHK("runt", 0, rises)
      `CHK("falls", 1'b1, falls <= 17)
      `CHK("low phase", 1'b1, lo > HALF1)
      `CHK("copies", 0, bad)
      `CHK("follow", 1'b1, flips >= 6)
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial begin
      {errors, compares} = '0;
      {rst_n, amp0, bypass, sel_v, sel_en} = 5'h0E;
      amp1 = 1'b1;
      {run, lvl, noise} = 6'h30;
      cyc(8);
      `CHK("rst fan", 8'h00, fan)
      `CHK("rst busy", 1'b1, busy)
      cyc(8);
      rst_n = 1'b1;
      cyc(40);
      `CHK("init busy", 1'b1, busy)
      wait_busy(1'b0);
      bypass = 1'b1;
      run = 2'h0;
      foreach (rows[i]) begin
         sel_en = rows[i].en;
         sel_v = rows[i].s;
         lvl = rows[i].l;
         cyc(8);
         `CHK("mux", rows[i].e, fan)
      end
      // Input zero stuck high while input one runs.
      {sel_en, sel_v, lvl, run} = 6'h26;
      cyc(20);
      bypass = 1'b0;
      cyc(20);
      switch_to(1'b1, first, hi);
      `CHK("hold hi", 8'hFF, first)
      `CHK("high phase", 1'b1, hi > HALF1)
      // Input one stuck low while input zero runs.
      {lvl, run} = 4'h1;
      cyc(20);
      switch_to(1'b0, first, hi);
      `CHK("hold lo", 8'h00, first)
      `CHK("no high", 0, hi)
      // Input zero loses amplitude after a high level, then turns to noise.
      {lvl, run} = 4'h6;
      cyc(20);
      amp0 = 1'b0;
      cyc(10);
      noise = 2'h1;
      repeat (40) begin
         cyc(1);
         `CHK("failsafe", 8'hFF, fan)
      end
      switch_to(1'b1, first, hi);
      `CHK("lost hi", 8'hFF, first)
      // Input one loses amplitude while selected, so the output must freeze.
      amp1 = 1'b0;
      cyc(6);
      first = fan;
      repeat (20) begin
         cyc(1);
         `CHK("failsafe one", first, fan)
      end
      // Both clocks healthy: old clock, a low gap, then the new clock.
      {amp0, amp1, noise, run} = 6'h33;
      cyc(20);
      switch_to(1'b0, first, hi);
      `CHK("old follow", 1'b1, hi <= HALF1)
      // Reset in mid-run; the select must still be taken during initialisation.
      {lvl, run} = 4'h4;
      cyc(10);
      rst_n = 1'b0;
      cyc(2);
      `CHK("rerst fan", 8'h00, fan)
      `CHK("rerst busy", 1'b1, busy)
      rst_n = 1'b1;
      wait_busy(1'b0);
      cyc(8);
      `CHK("rerst sel", 8'hFF, fan)
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
